// File: rtl/mre_exec.sv
// Purpose: Executes store, option load, software reset, return and no-op.
// Assumes: Instructions arrive decoded, synchronous to clk_sys_in.
// Notes:   File writes leave one cycle after the instruction is taken.
//
// The strobed register port and the placing of the registers were left to the implementer.
`include "mre_consts.svh"

module mre_exec import mre_pkg::*; (
	input  wire logic                          clk_sys_in,
	input  wire logic                          rst_n_in,
	input  wire logic                          instr_valid_in,
	input  wire mre_instr_t                    instr_in,
	output logic                               instr_ready_out,
	input  wire logic [`MRE_PC_W-1:0]          stack_top_in,
	output logic                               stack_pop_out,
	output logic                               pc_load_out,
	output logic      [`MRE_PC_W-1:0]          pc_out,
	output mre_fwr_t                           fwr_out,
	output logic                               device_reset_req_out,
	output logic      [`MRE_DATA_W-1:0]        option_out,
	output logic                               global_interrupt_enable_out,
	input  wire logic [`MRE_BUS_ADDR_W-1:0]    bus_addr_in,
	input  wire logic [`MRE_DATA_W-1:0]        bus_wdata_in,
	input  wire logic                          bus_wr_in,
	input  wire logic                          bus_rd_in,
	output logic      [`MRE_DATA_W-1:0]        bus_rdata_out
);
	logic [`MRE_DATA_W-1:0]  acc_reg;
	logic [`MRE_DATA_W-1:0]  acc_next;
	logic [`MRE_DATA_W-1:0]  option_reg;
	logic [`MRE_DATA_W-1:0]  option_next;
	logic [`MRE_PTR_W-1:0]   ptr0_reg;
	logic [`MRE_PTR_W-1:0]   ptr0_next;
	logic [`MRE_PTR_W-1:0]   ptr1_reg;
	logic [`MRE_PTR_W-1:0]   ptr1_next;
	logic [`MRE_DATA_W-1:0]  intctl_reg;
	logic [`MRE_DATA_W-1:0]  intctl_next;
	logic [`MRE_DATA_W-1:0]  pwrctl_reg;
	logic [`MRE_DATA_W-1:0]  pwrctl_next;
	logic [`MRE_DATA_W-1:0]  status_reg;
	logic [`MRE_DATA_W-1:0]  status_next;
	logic                    ready_reg;
	logic                    pop_reg;
	logic                    pc_load_reg;
	logic [`MRE_PC_W-1:0]    pc_reg;
	mre_fwr_t                fwr_reg;
	mre_fwr_t                fwr_next;
	logic                    rst_req_reg;
	logic [`MRE_DATA_W-1:0]  rdata_reg;
	logic [`MRE_DATA_W-1:0]  rdata_next;
	logic                    intctl_ret_pending;

	wire logic               take;
	wire logic               is_direct;
	wire logic               is_indir;
	wire logic               is_option;
	wire logic               is_reset;
	wire logic               is_ret_int;
	wire logic               is_ret;
	wire logic               seq_idle;
	wire logic               seq_pop;
	wire logic [`MRE_PTR_W-1:0] sel_ptr;
	wire logic [`MRE_PTR_W-1:0] ind_ea;
	wire logic [`MRE_PTR_W-1:0] ind_ptr_new;
	wire logic [`MRE_PTR_W-1:0] direct_addr;
	wire logic               win0_hit;
	wire logic               win1_hit;
	wire logic               wr_acc;
	wire logic               wr_option;
	wire logic               wr_p0lo;
	wire logic               wr_p0hi;
	wire logic               wr_p1lo;
	wire logic               wr_p1hi;
	wire logic               wr_intctl;
	wire logic               wr_pwrctl;
	wire logic               wr_status;

	// Opcode match gated by the handshake, so a word runs only in a cycle where valid and ready are both high.
	function automatic logic op_hit(input logic taken, input mre_op_t op, input mre_op_t code);
		op_hit = taken && (op == code);
	endfunction

	// Register index compare shared by the software write decoder.
	function automatic logic reg_hit(
		input logic [`MRE_BUS_ADDR_W-1:0] addr,
		input logic [`MRE_BUS_ADDR_W-1:0] idx
	);
		reg_hit = (addr == idx);
	endfunction

	// Instruction decode.
	assign take       = instr_valid_in && ready_reg;
	assign is_direct  = op_hit(take, instr_in.op, MRE_OP_STORE_DIRECT);
	assign is_indir   = op_hit(take, instr_in.op, MRE_OP_STORE_INDIR);
	assign is_option  = op_hit(take, instr_in.op, MRE_OP_LOAD_OPTION);
	assign is_reset   = op_hit(take, instr_in.op, MRE_OP_SOFT_RESET);
	assign is_ret_int = op_hit(take, instr_in.op, MRE_OP_RET_INT);
	assign is_ret     = is_ret_int || op_hit(take, instr_in.op, MRE_OP_RET_SUB);

	// Window addresses resolve through the current pointer, never to storage.
	assign win0_hit    = (instr_in.f_addr == `MRE_WINDOW0_ADDR);
	assign win1_hit    = (instr_in.f_addr == `MRE_WINDOW1_ADDR);
	assign direct_addr = win0_hit ? ptr0_reg :
	                     win1_hit ? ptr1_reg :
	                     {{(`MRE_PTR_W-`MRE_FADDR_W){1'b0}}, instr_in.f_addr};

	// Only the selected pointer steps; the other keeps its value.
	assign sel_ptr = instr_in.ptr_sel ? ptr1_reg : ptr0_reg;

	mre_ptr_unit u_ptr (
		.ptr_in      (sel_ptr),
		.mode_in     (instr_in.indirect_mode_code),
		.rel_in      (instr_in.rel),
		.offset_in   (instr_in.offset),
		.ea_out      (ind_ea),
		.ptr_new_out (ind_ptr_new)
	);

	// The sequencer times ready and the enable set; the pop is registered from the take. Ready comes back two cycles after a return is taken.
	mre_ret_seq u_ret (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.start_in   (is_ret),
		.idle_out   (seq_idle),
		.pop_out    (seq_pop)
	);

	// Software port decode.
	assign wr_acc    = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_ACC);
	assign wr_option = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_OPTION);
	assign wr_p0lo   = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_PTR0_LO);
	assign wr_p0hi   = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_PTR0_HI);
	assign wr_p1lo   = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_PTR1_LO);
	assign wr_p1hi   = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_PTR1_HI);
	assign wr_intctl = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_INTCTL);
	assign wr_pwrctl = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_PWRCTL);
	assign wr_status = bus_wr_in && reg_hit(bus_addr_in, `MRE_REG_STATUS);

	// Accumulator and status are only touched by software here.
	assign acc_next    = wr_acc ? bus_wdata_in : acc_reg;
	assign status_next = wr_status ? bus_wdata_in : status_reg;

	// An instruction in the same cycle as a software write wins the register.
	assign option_next = is_option ? acc_reg :
	                     wr_option ? bus_wdata_in : option_reg;

	// A pointer step from an indirect store overrides a software byte write in the same cycle.
	always_comb begin
		ptr0_next = ptr0_reg;
		ptr1_next = ptr1_reg;
		if (wr_p0lo) begin
			ptr0_next[7:0] = bus_wdata_in;
		end
		if (wr_p0hi) begin
			ptr0_next[15:8] = bus_wdata_in;
		end
		if (wr_p1lo) begin
			ptr1_next[7:0] = bus_wdata_in;
		end
		if (wr_p1hi) begin
			ptr1_next[15:8] = bus_wdata_in;
		end
		if (is_indir && !instr_in.ptr_sel) begin
			ptr0_next = ind_ptr_new;
		end else if (is_indir) begin
			ptr1_next = ind_ptr_new;
		end
	end

	// The enable set rides the pop cycle and beats a software write in that cycle.
	always_comb begin
		intctl_next = wr_intctl ? bus_wdata_in : intctl_reg;
		if (seq_pop && pc_load_reg && intctl_ret_pending) begin
			intctl_next[`MRE_GIE_BIT] = 1'b1;
		end
	end

	// The hardware clear beats a software write that lands in the same cycle.
	always_comb begin
		pwrctl_next = wr_pwrctl ? bus_wdata_in : pwrctl_reg;
		if (is_reset) begin
			pwrctl_next[`MRE_RI_BIT] = 1'b0;
		end
	end

	// The write leaves one cycle after the take; pre modes address the stepped pointer, post modes the pointer before the step.
	always_comb begin
		fwr_next = '0;
		if (is_direct) begin
			fwr_next.en   = 1'b1;
			fwr_next.addr = direct_addr;
			fwr_next.data = acc_reg;
		end else if (is_indir) begin
			fwr_next.en   = 1'b1;
			fwr_next.addr = ind_ea;
			fwr_next.data = acc_reg;
		end
	end

	// Idle cycles and unmapped indices read as zero.
	always_comb begin
		rdata_next = '0;
		if (!bus_rd_in) begin
			rdata_next = '0;
		end else if (bus_addr_in == `MRE_REG_ACC) begin
			rdata_next = acc_reg;
		end else if (bus_addr_in == `MRE_REG_OPTION) begin
			rdata_next = option_reg;
		end else if (bus_addr_in == `MRE_REG_PTR0_LO) begin
			rdata_next = ptr0_reg[7:0];
		end else if (bus_addr_in == `MRE_REG_PTR0_HI) begin
			rdata_next = ptr0_reg[15:8];
		end else if (bus_addr_in == `MRE_REG_PTR1_LO) begin
			rdata_next = ptr1_reg[7:0];
		end else if (bus_addr_in == `MRE_REG_PTR1_HI) begin
			rdata_next = ptr1_reg[15:8];
		end else if (bus_addr_in == `MRE_REG_INTCTL) begin
			rdata_next = intctl_reg;
		end else if (bus_addr_in == `MRE_REG_PWRCTL) begin
			rdata_next = pwrctl_reg;
		end else if (bus_addr_in == `MRE_REG_STATUS) begin
			rdata_next = status_reg;
		end
	end

	// Remembers that the return in flight is the interrupt kind.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			intctl_ret_pending <= 1'b0;
		end else if (is_ret) begin
			intctl_ret_pending <= is_ret_int;
		end
	end

	// The soft reset raises a request and clears the RI bit of pwrctl; the outer device reset reloads these registers.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc_reg    <= `MRE_ACC_RST;
			option_reg <= `MRE_OPTION_RST;
			ptr0_reg   <= `MRE_PTR_RST;
			ptr1_reg   <= `MRE_PTR_RST;
			intctl_reg <= `MRE_INTCTL_RST;
			pwrctl_reg <= `MRE_PWRCTL_RST;
			status_reg <= `MRE_STATUS_RST;
		end else begin
			acc_reg    <= acc_next;
			option_reg <= option_next;
			ptr0_reg   <= ptr0_next;
			ptr1_reg   <= ptr1_next;
			intctl_reg <= intctl_next;
			pwrctl_reg <= pwrctl_next;
			status_reg <= status_next;
		end
	end

	// A return holds ready low for its second cycle; other opcodes never do.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ready_reg   <= 1'b1;
			pop_reg     <= 1'b0;
			pc_load_reg <= 1'b0;
			pc_reg      <= '0;
			fwr_reg     <= '0;
			rst_req_reg <= 1'b0;
			rdata_reg   <= '0;
		end else begin
			ready_reg   <= seq_idle && !is_ret;
			pop_reg     <= is_ret;
			pc_load_reg <= is_ret;
			pc_reg      <= is_ret ? stack_top_in : pc_reg;
			fwr_reg     <= fwr_next;
			rst_req_reg <= is_reset;
			rdata_reg   <= rdata_next;
		end
	end

	// A no-op is taken and retires without touching any state.

	// Every output is a register copy, so nothing combinational leaves the block.
	assign instr_ready_out             = ready_reg;
	assign stack_pop_out               = pop_reg;
	assign pc_load_out                 = pc_load_reg;
	assign pc_out                      = pc_reg;
	assign fwr_out                     = fwr_reg;
	assign device_reset_req_out        = rst_req_reg;
	assign option_out                  = option_reg;
	assign global_interrupt_enable_out = intctl_reg[`MRE_GIE_BIT];
	assign bus_rdata_out               = rdata_reg;
endmodule

// File: rtl/mre_consts.svh
// Purpose: Offsets, field positions, reset values and widths of the executor.
// Assumes: Included by its bare name from package and design files.
// Notes:   Definitions only.
`ifndef MRE_CONSTS_SVH
`define MRE_CONSTS_SVH

`define MRE_DATA_W        8
`define MRE_PTR_W         16
`define MRE_PC_W          15
`define MRE_FADDR_W       7
`define MRE_OFS_W         6
`define MRE_BUS_ADDR_W    4

// Register indices on the plain software port.
`define MRE_REG_ACC       4'h0
`define MRE_REG_OPTION    4'h1
`define MRE_REG_PTR0_LO   4'h2
`define MRE_REG_PTR0_HI   4'h3
`define MRE_REG_PTR1_LO   4'h4
`define MRE_REG_PTR1_HI   4'h5
`define MRE_REG_INTCTL    4'h6
`define MRE_REG_PWRCTL    4'h7
`define MRE_REG_STATUS    4'h8

// Direct addresses that stand for the two indirect windows.
`define MRE_WINDOW0_ADDR  7'h00
`define MRE_WINDOW1_ADDR  7'h01

// Field positions.
`define MRE_GIE_BIT       7
`define MRE_RI_BIT        2

// Reset values.
`define MRE_ACC_RST       8'h00
`define MRE_OPTION_RST    8'hff
`define MRE_PTR_RST       16'h0000
`define MRE_INTCTL_RST    8'h00
`define MRE_PWRCTL_RST    8'h04
`define MRE_STATUS_RST    8'h18

// Indirect mode codes.
`define MRE_MODE_PREINC   2'b00
`define MRE_MODE_PREDEC   2'b01
`define MRE_MODE_POSTINC  2'b10
`define MRE_MODE_POSTDEC  2'b11

`endif

// File: rtl/mre_pkg.sv
// Purpose: Types shared by the instruction executor files.
// Assumes: mre_consts.svh gives the widths.
// Notes:   Opcodes are an already decoded form, not instruction words.
`include "mre_consts.svh"

package mre_pkg;

	typedef enum logic [2:0] {
		MRE_OP_NOP          = 3'h0,
		MRE_OP_STORE_DIRECT = 3'h1,
		MRE_OP_STORE_INDIR  = 3'h2,
		MRE_OP_LOAD_OPTION  = 3'h3,
		MRE_OP_SOFT_RESET   = 3'h4,
		MRE_OP_RET_INT      = 3'h5,
		MRE_OP_RET_SUB      = 3'h6
	} mre_op_t;

	typedef struct packed {
		mre_op_t                     op;
		logic [`MRE_FADDR_W-1:0]     f_addr;
		logic                        ptr_sel;
		logic [1:0]                  indirect_mode_code;
		logic                        rel;
		logic signed [`MRE_OFS_W-1:0] offset;
	} mre_instr_t;

	typedef struct packed {
		logic                    en;
		logic [`MRE_PTR_W-1:0]   addr;
		logic [`MRE_DATA_W-1:0]  data;
	} mre_fwr_t;

	typedef enum logic [1:0] {
		MRE_RS_IDLE = 2'b00,
		MRE_RS_POP  = 2'b01,
		MRE_RS_HOLD = 2'b11
	} mre_ret_state_t;

	// Pointer step with natural 16-bit wrap-around in both directions.
	function automatic logic [`MRE_PTR_W-1:0] mre_ptr_step(
		input logic [`MRE_PTR_W-1:0] p,
		input logic                  up
	);
		mre_ptr_step = up ? p + 16'h0001 : p - 16'h0001;
	endfunction

endpackage

// File: rtl/mre_ptr_unit.sv
// Purpose: Effective address and updated pointer for an indirect store.
// Assumes: Pure combinational; the caller commits the result.
// Notes:   Relative form leaves the pointer untouched.
`include "mre_consts.svh"

module mre_ptr_unit import mre_pkg::*; (
	input  wire logic [`MRE_PTR_W-1:0]         ptr_in,
	input  wire logic [1:0]                    mode_in,
	input  wire logic                          rel_in,
	input  wire logic signed [`MRE_OFS_W-1:0]  offset_in,
	output logic      [`MRE_PTR_W-1:0]         ea_out,
	output logic      [`MRE_PTR_W-1:0]         ptr_new_out
);
	wire logic                  step_up;
	wire logic [`MRE_PTR_W-1:0] stepped;
	wire logic                  pre;
	wire logic [`MRE_PTR_W-1:0] ofs_ext;

	assign step_up = (mode_in == `MRE_MODE_PREINC) || (mode_in == `MRE_MODE_POSTINC);
	assign pre     = (mode_in == `MRE_MODE_PREINC) || (mode_in == `MRE_MODE_PREDEC);
	assign stepped = mre_ptr_step(ptr_in, step_up);
	assign ofs_ext = {{(`MRE_PTR_W-`MRE_OFS_W){offset_in[`MRE_OFS_W-1]}}, offset_in};

	assign ea_out      = rel_in ? ptr_in + ofs_ext : (pre ? stepped : ptr_in);
	assign ptr_new_out = rel_in ? ptr_in : stepped;
endmodule

// File: rtl/mre_ret_seq.sv
// Purpose: Two-cycle sequencer for the return instructions.
// Assumes: start_in is a one-cycle pulse, raised only while the sequencer is idle.
// Notes:   Pop is signalled in the return's second cycle, then the sequencer is idle again.
module mre_ret_seq import mre_pkg::*; (
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	input  wire logic start_in,
	output logic      idle_out,
	output logic      pop_out
);
	mre_ret_state_t state_reg;
	mre_ret_state_t state_next;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MRE_RS_IDLE: begin
				if (start_in) begin
					state_next = MRE_RS_POP;
				end
			end
			MRE_RS_POP:  state_next = MRE_RS_IDLE;
			default:     state_next = MRE_RS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= MRE_RS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Idle looks one cycle ahead so that a registered ready returns in time.
	assign idle_out = (state_next == MRE_RS_IDLE);
	assign pop_out  = (state_reg == MRE_RS_POP);
endmodule

// File: testbench/mre_exec_props.sv
// Purpose: Port-level properties of the instruction executor.
// Assumes: Bound to mre_exec; one clock domain, asynchronous active-low reset.
// Notes:   Stored data values are predicted by the bench, not here.
`include "mre_consts.svh"
module mre_exec_props import mre_pkg::*; (
	input wire logic                       clk_sys_in,
	input wire logic                       rst_n_in,
	input wire logic                       instr_valid_in,
	input wire mre_instr_t                 instr_in,
	input wire logic                       instr_ready_out,
	input wire logic [`MRE_PC_W-1:0]       stack_top_in,
	input wire logic                       stack_pop_out,
	input wire logic                       pc_load_out,
	input wire logic [`MRE_PC_W-1:0]       pc_out,
	input wire mre_fwr_t                   fwr_out,
	input wire logic                       device_reset_req_out,
	input wire logic [`MRE_DATA_W-1:0]     option_out,
	input wire logic                       global_interrupt_enable_out,
	input wire logic [`MRE_BUS_ADDR_W-1:0] bus_addr_in,
	input wire logic [`MRE_DATA_W-1:0]     bus_wdata_in,
	input wire logic                       bus_wr_in,
	input wire logic                       bus_rd_in,
	input wire logic [`MRE_DATA_W-1:0]     bus_rdata_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	wire mre_op_t op = instr_in.op;
	wire logic take = instr_valid_in && instr_ready_out;
	wire logic take_ri = take && op == MRE_OP_RET_INT;
	wire logic take_ret = take_ri || (take && op == MRE_OP_RET_SUB);
	wire logic take_st = take && (op == MRE_OP_STORE_DIRECT || op == MRE_OP_STORE_INDIR);
	wire logic opt_wr = bus_wr_in && bus_addr_in == `MRE_REG_OPTION;
	wire logic ie_wr = bus_wr_in && bus_addr_in == `MRE_REG_INTCTL;
	sequence s_pop; stack_pop_out && pc_load_out && !instr_ready_out; endsequence
	sequence s_done; !stack_pop_out && !pc_load_out && instr_ready_out; endsequence
	property p_ret_pc; take_ret |=> s_pop ##0 pc_out == $past(stack_top_in); endproperty
	property p_ret_two; take_ret |=> s_pop ##1 s_done; endproperty
	property p_gie_set; take_ri |-> ##2 global_interrupt_enable_out; endproperty
	property p_gie_cause; $rose(global_interrupt_enable_out) |-> $past(take_ri, 2) || $past(ie_wr);
	endproperty
	property p_direct; take && op == MRE_OP_STORE_DIRECT && instr_in.f_addr > 7'h01
		|=> fwr_out.en && fwr_out.addr == {9'h000, $past(instr_in.f_addr)}; endproperty
	property p_store_one; take_st |=> fwr_out.en && instr_ready_out; endproperty
	property p_fwr_cause; fwr_out.en |-> $past(take_st); endproperty
	property p_opt_hold; !(take && op == MRE_OP_LOAD_OPTION) && !opt_wr |=> $stable(option_out);
	endproperty
	property p_srst; take && op == MRE_OP_SOFT_RESET |=> device_reset_req_out ##1 !device_reset_req_out;
	endproperty
	property p_nop; take && op == MRE_OP_NOP |=> !fwr_out.en && !stack_pop_out && !device_reset_req_out;
	endproperty
	a_ret_pc: assert property (p_ret_pc) else $error("popped value not loaded");
	a_ret_two: assert property (p_ret_two) else $error("return not two cycles");
	a_gie_set: assert property (p_gie_set) else $error("enable not set");
	a_gie_cause: assert property (p_gie_cause) else $error("enable rose unasked");
	a_direct: assert property (p_direct) else $error("direct store address wrong");
	a_store_one: assert property (p_store_one) else $error("store not one cycle");
	a_fwr_cause: assert property (p_fwr_cause) else $error("spurious file write");
	a_opt_hold: assert property (p_opt_hold) else $error("option changed unasked");
	a_srst: assert property (p_srst) else $error("reset request not a pulse");
	a_nop: assert property (p_nop) else $error("no-op had an effect");
endmodule

bind mre_exec mre_exec_props u_props (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out),
	.stack_top_in(stack_top_in), .stack_pop_out(stack_pop_out), .pc_load_out(pc_load_out),
	.pc_out(pc_out), .fwr_out(fwr_out), .device_reset_req_out(device_reset_req_out),
	.option_out(option_out), .global_interrupt_enable_out(global_interrupt_enable_out),
	.bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in),
	.bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out));

// File: testbench/tb_move_return_instr_exec.sv
// Purpose: Self-checking bench for the instruction executor.
// Assumes: The bench drives every port; stimulus comes from a fixed-seed shift register.
// Notes:   Pointers are mirrored here so that wrap and window cases are predicted.
`include "mre_consts.svh"
module tb_move_return_instr_exec import mre_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_in = 0, rst_n_in = 0, instr_valid_in = 0, bus_wr_in = 0, bus_rd_in = 0;
	mre_instr_t  instr_in = '0;
	logic [14:0] stack_top_in = '0, pc_out;
	logic [3:0]  bus_addr_in = '0;
	logic [7:0]  bus_wdata_in = '0, acc, option_out, bus_rdata_out;
	logic [15:0] ptr [2];
	logic [31:0] seed = 32'hd7f5;
	int          fails = 0, tests_run = 0, cyc = 0;
	logic        instr_ready_out, stack_pop_out, pc_load_out, device_reset_req_out, global_interrupt_enable;
	mre_fwr_t    fwr_out;

	mre_exec dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
		.instr_in(instr_in), .instr_ready_out(instr_ready_out), .stack_top_in(stack_top_in),
		.stack_pop_out(stack_pop_out), .pc_load_out(pc_load_out), .pc_out(pc_out),
		.fwr_out(fwr_out), .device_reset_req_out(device_reset_req_out), .option_out(option_out),
		.global_interrupt_enable_out(global_interrupt_enable), .bus_addr_in(bus_addr_in),
		.bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
		.bus_rdata_out(bus_rdata_out));

	always #5 clk_sys_in = ~clk_sys_in;

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
		return seed;
	endfunction

	function automatic logic [15:0] ea_f(logic [15:0] p, logic [1:0] m, logic r, logic [5:0] o);
		if (r)
			return p + {{10{o[5]}}, o};
		return (m == 2'b00) ? p + 16'h1 : (m == 2'b01) ? p - 16'h1 : p;
	endfunction

	function automatic logic [15:0] ptr_f(logic [15:0] p, logic [1:0] m, logic r);
		if (r)
			return p;
		return m[0] ? p - 16'h1 : p + 16'h1;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		bus_wr_in <= 1'b1;
		bus_addr_in <= a;
		bus_wdata_in <= d;
		@(posedge clk_sys_in);
		bus_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		bus_rd_in <= 1'b1;
		bus_addr_in <= a;
		@(posedge clk_sys_in);
		bus_rd_in <= 1'b0;
		#1;
		chk(bus_rdata_out, exp);
	endtask

	// Returns one time unit after the taking edge, where the registered answer stands.
	task automatic exec(input mre_instr_t i);
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b1;
		instr_in <= i;
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b0;
		#1;
	endtask

	task automatic setptr(input int n, input logic [15:0] v);
		wr(4'(2 + 2 * n), v[7:0]);
		wr(4'(3 + 2 * n), v[15:8]);
		ptr[n] = v;
	endtask

	task automatic chkptr(input int n);
		rd(4'(2 + 2 * n), ptr[n][7:0]);
		rd(4'(3 + 2 * n), ptr[n][15:8]);
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			final_report();
		end
	end

	initial begin
		logic [7:0]  rv [9];
		logic        n;
		logic [1:0]  m;
		logic        r;
		logic [5:0]  o;
		logic [6:0]  f;
		logic [15:0] p;
		logic [14:0] st;
		rv = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h18};
		ptr = '{16'h0000, 16'h0000};
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		foreach (rv[k]) rd(4'(k), rv[k]);
		rd(4'hf, 8'h00);
		for (int k = 0; k < 8; k++) begin
			acc = 8'(rnd());
			f = (k == 0) ? 7'h7f : 7'(rnd()) | 7'h02;
			wr(`MRE_REG_ACC, acc);
			exec('{MRE_OP_STORE_DIRECT, f, 1'b0, 2'b00, 1'b0, 6'h00});
			chk(fwr_out.en, 16'h1);
			chk(fwr_out.addr, {9'h000, f});
			chk(fwr_out.data, acc);
		end
		// Pointer corners first so that every mode code meets the wrap in its own step direction.
		for (int k = 0; k < 16; k++) begin
			n = k[0];
			m = k[2:1];
			r = (k >= 12);
			o = (k == 12) ? 6'h20 : (k == 13) ? 6'h1f : 6'(rnd());
			p = (k < 8) ? (m[0] ? 16'h0000 : 16'hffff) : 16'(rnd());
			acc = 8'(rnd());
			wr(`MRE_REG_ACC, acc);
			setptr(int'(n), p);
			exec('{MRE_OP_STORE_INDIR, 7'h00, n, m, r, o});
			chk(fwr_out.addr, ea_f(p, m, r, o));
			chk(fwr_out.data, acc);
			ptr[n] = ptr_f(p, m, r);
			chkptr(0);
			chkptr(1);
		end
		rd(`MRE_REG_STATUS, 8'h18);
		for (int w = 0; w < 2; w++) begin
			exec('{MRE_OP_STORE_DIRECT, 7'(w), 1'b0, 2'b00, 1'b0, 6'h00});
			chk(fwr_out.addr, ptr[w]);
			chk(fwr_out.data, acc);
		end
		acc = 8'(rnd());
		wr(`MRE_REG_ACC, acc);
		exec('{MRE_OP_LOAD_OPTION, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00});
		chk(option_out, acc);
		rd(`MRE_REG_OPTION, acc);
		exec('{MRE_OP_NOP, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00});
		chk({fwr_out.en, stack_pop_out, pc_load_out, device_reset_req_out}, 16'h0);
		chk(option_out, acc);
		chkptr(0);
		exec('{MRE_OP_SOFT_RESET, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00});
		chk(device_reset_req_out, 16'h1);
		rd(`MRE_REG_PWRCTL, 8'h00);
		for (int k = 0; k < 2; k++) begin
			wr(`MRE_REG_INTCTL, 8'h00);
			st = 15'(rnd());
			stack_top_in <= st;
			exec('{k ? MRE_OP_RET_SUB : MRE_OP_RET_INT, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00});
			chk({stack_pop_out, pc_load_out, instr_ready_out}, 16'h6);
			chk(pc_out, st);
			@(posedge clk_sys_in);
			#1;
			chk({stack_pop_out, instr_ready_out, global_interrupt_enable}, {14'h1, k == 0});
			rd(`MRE_REG_INTCTL, (k == 0) ? 8'h80 : 8'h00);
		end
		final_report();
	end
endmodule
